// >>> rtl/sfsw_pkg.sv
`default_nettype none
package sfsw_pkg;

   // -----------------------------------------------------------------
   // Opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OP_READ          = 8'h03;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS   = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_FAST_READ     = 8'h0b;
   localparam logic [7:0] OP_DUAL_READ     = 8'h3b;
   localparam logic [7:0] OP_ENH_RESET     = 8'hff;

   // -----------------------------------------------------------------
   // Frame bit counts (bits received, including the current one)
   // -----------------------------------------------------------------
   localparam logic [6:0] CNT_FIRST      = 7'h01;
   localparam logic [6:0] CNT_OPCODE     = 7'h08;
   localparam logic [6:0] CNT_ADDR_FIRST = 7'h09;
   localparam logic [6:0] CNT_BYTE2      = 7'h10;
   localparam logic [6:0] CNT_BYTE3      = 7'h18;
   localparam logic [6:0] CNT_ADDR_LAST  = 7'h20;
   localparam logic [6:0] CNT_MODE_END   = 7'h28;
   localparam logic [6:0] CNT_MAX        = 7'h7f;
   localparam logic [6:0] CNT_NONE       = 7'h00;

   // -----------------------------------------------------------------
   // Output shifting, dummy clocks, protection blocks
   // -----------------------------------------------------------------
   localparam logic [2:0] SHIFTS_SINGLE = 3'h7;
   localparam logic [2:0] SHIFTS_DUAL   = 3'h3;
   localparam logic [3:0] DUMMY_DC_ONE  = 4'h8;
   localparam logic [3:0] DUMMY_DC_ZERO = 4'h6;
   localparam logic [6:0] NUM_BLOCKS    = 7'h40;
   localparam logic [3:0] BP_FULL       = 4'h7;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int STATUS_WRITE_CYCLE_TIME_NS = 40000;
   localparam int CLOCK_PERIOD_NS            = 10;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      WS_IDLE  = 2'b01,
      WS_WRITE = 2'b10
   } sfsw_wstate_e;

   typedef struct packed {
      logic       statusWriteDisableBit;
      logic       quadEnableBit;
      logic [3:0] blockProtect;
      logic       writeEnableLatch;
      logic       busyFlag;
   } sfsw_status_s;

   typedef struct packed {
      logic       dummyCycleSelect;
      logic [2:0] reservedHigh;
      logic       topBottomSelect;
      logic [2:0] reservedLow;
   } sfsw_config_s;

   typedef struct packed {
      logic dualOutputLine1;
      logic line1Oe;
      logic dualOutputLine0;
      logic line0Oe;
   } sfsw_link_s;

endpackage

`default_nettype wire

// >>> rtl/sfsw_flash_core.sv
// Contract
// - Dummy-cycle select one gives eight quad dummy clocks, zero gives six.
// - Status write needs write-enable latch set by an earlier write-enable.
// - Status write changes protect, quad-enable, disable bits; never latch or busy.
// - Status write refused while hardware protection mode is active.
// - Select must rise on a byte boundary or the status write is dropped.
// - Select rise starts timed cycle; busy held, then busy and latch clear.
// - Hardware protection is disable bit one with protect pin low and quad enable zero.
// - Disable bit zero, or pin high: write-enable works, bits writable.
// - Hardware protection ends only when the protect pin goes high.
// - Quad enable switches hardware protection off entirely.
// - Protected region rejects program and erase.
// - Address sampled on rising clock, data shifted out on falling.
// - Read address increments per byte and wraps to zero.
// - Select rise ends a read and stops output drive.
// - Fast and dual reads rejected while a write cycle is busy.
// - Complementary mode byte keeps enhanced mode; other values leave it.
// - Status byte layout: disable, quad, four protect, latch, busy.
// - Latch zero ignores program, erase and status write.
// - Quad enable defaults zero, keeping the protect pin active.
`timescale 1ns/10ps
`default_nettype none

module sfsw_flash_core #(
   parameter int ADDR_W       = 24,
   parameter int WRITE_CYCLES = (sfsw_pkg::STATUS_WRITE_CYCLE_TIME_NS
                                 + sfsw_pkg::CLOCK_PERIOD_NS - 1)
                                / sfsw_pkg::CLOCK_PERIOD_NS
) (
   // Core clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   // Serial link
   input  wire logic                  sclk,
   input  wire logic                  csN,
   input  wire logic                  serialIn,
   input  wire logic                  writeProtectIo2PinN,
   output var  sfsw_pkg::sfsw_link_s  linkOut,
   // Array read port, link domain
   output logic [ADDR_W-1:0]          arrayAddr,
   input  wire logic [7:0]            arrayData,
   // Program and erase side, core domain
   input  wire logic                  peBusy,
   input  wire logic [5:0]            peBlock,
   output logic                       peBlocked,
   // Status view
   output var  sfsw_pkg::sfsw_status_s statusReg,
   output var  sfsw_pkg::sfsw_config_s configReg,
   output logic                       hardwareProtectionMode,
   output logic                       softwareProtectionMode,
   output logic [3:0]                 quadDummyClocks
);
   import sfsw_pkg::*;

   localparam int TW = $clog2(WRITE_CYCLES + 1);

   // A write cycle shorter than two clocks could not hold busy long enough to be seen.
   if (ADDR_W < 8 || ADDR_W > 24 || WRITE_CYCLES < 2) begin : g_check
      $error("sfsw_flash_core: unsupported parameter values");
   end

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic [6:0] readStart(input logic [7:0] op);
      case (op)
         OP_READ_STATUS: readStart = CNT_OPCODE;
         OP_READ:        readStart = CNT_ADDR_LAST;
         OP_FAST_READ:   readStart = CNT_MODE_END;
         OP_DUAL_READ:   readStart = CNT_MODE_END;
         default:        readStart = CNT_NONE;
      endcase
   endfunction

   function automatic logic regionHit(input logic [3:0] bp, input logic tb,
                                      input logic [5:0] blk);
      logic [6:0] span;
      span = (bp == 4'h0) ? 7'h00 :
             (bp > BP_FULL) ? NUM_BLOCKS : 7'(7'h01 << (bp - 4'h1));
      regionHit = tb ? ({1'b0, blk} < span) : ({1'b0, blk} >= NUM_BLOCKS - span);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] csSync;
   logic [2:0] wpSync;
   logic       csHigh;
   logic       csHighQ;
   logic       wpHigh;
   logic       csRise;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         csSync <= 3'h7;
         wpSync <= 3'h7;
      end else begin
         csSync <= {csSync[1:0], csN};
         wpSync <= {wpSync[1:0], writeProtectIo2PinN};
      end
   end

   // A change counts only once the second and third stages agree.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         csHigh  <= 1'b1;
         csHighQ <= 1'b1;
         wpHigh  <= 1'b1;
      end else begin
         if (csSync[1] == csSync[2]) begin
            csHigh <= csSync[2];
         end
         if (wpSync[1] == wpSync[2]) begin
            wpHigh <= wpSync[2];
         end
         csHighQ <= csHigh;
      end
   end

   assign csRise = csHigh && !csHighQ;

   // ---------------------------------------------------------------
   // Status, configuration and protection
   // ---------------------------------------------------------------
   sfsw_wstate_e wstate;
   logic [TW-1:0] timer;
   logic          status_write_disable_bit;
   logic          qe;
   logic [3:0]    bp;
   logic          write_enable_latch;
   logic          dc;
   logic          tb;
   logic          busyNow;
   logic          swDone;
   logic          cmdWe;
   logic          cmdWd;
   logic          cmdSw;
   logic [6:0]    frameCnt;
   logic [7:0]    frameOpc;
   sfsw_status_s  frameData1;
   sfsw_config_s  frameData2;

   assign busyNow = (wstate == WS_WRITE) || peBusy;
   assign swDone  = (wstate == WS_WRITE) && (timer == '0);
   assign hardwareProtectionMode = status_write_disable_bit && !wpHigh && !qe;
   assign softwareProtectionMode = !hardwareProtectionMode;
   assign quadDummyClocks = dc ? DUMMY_DC_ONE : DUMMY_DC_ZERO;
   assign peBlocked = regionHit(bp, tb, peBlock);

   // The frame registers are quiet while select is high, so the core
   // reads them without a further crossing once the rise is seen.
   assign cmdWe = csRise && frameOpc == OP_WRITE_ENABLE && frameCnt == CNT_OPCODE
                  && !busyNow;
   assign cmdWd = csRise && frameOpc == OP_WRITE_DISABLE && frameCnt == CNT_OPCODE
                  && !busyNow;
   assign cmdSw = csRise && frameOpc == OP_STATUS_WRITE
                  && (frameCnt == CNT_BYTE2 || frameCnt == CNT_BYTE3)
                  && write_enable_latch && !busyNow
                  && !hardwareProtectionMode;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         wstate <= WS_IDLE;
         timer  <= '0;
      end else begin
         case (wstate)
            WS_IDLE: begin
               if (cmdSw) begin
                  wstate <= WS_WRITE;
                  timer  <= TW'(WRITE_CYCLES - 1);
               end
            end
            WS_WRITE: begin
               if (timer == '0) begin
                  wstate <= WS_IDLE;
               end else begin
                  timer <= timer - 1'b1;
               end
            end
            default: wstate <= WS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         write_enable_latch <= 1'b0;
      end else if (swDone) begin
         write_enable_latch <= 1'b0;
      end else if (cmdWe) begin
         write_enable_latch <= 1'b1;
      end else if (cmdWd) begin
         write_enable_latch <= 1'b0;
      end
   end

   // Non-volatile bits live in flops here and return to defaults on reset.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         status_write_disable_bit <= 1'b0;
         qe   <= 1'b0;
         bp   <= 4'h0;
      end else if (cmdSw) begin
         status_write_disable_bit <= frameData1.statusWriteDisableBit;
         qe   <= frameData1.quadEnableBit;
         bp   <= frameData1.blockProtect;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         dc <= 1'b0;
         tb <= 1'b0;
      end else if (cmdSw && frameCnt == CNT_BYTE3) begin
         dc <= frameData2.dummyCycleSelect;
         tb <= tb | frameData2.topBottomSelect;     // One-time bit: it can only be set.
      end
   end

   always_comb begin
      statusReg = '{statusWriteDisableBit: status_write_disable_bit, quadEnableBit: qe,
                    blockProtect: bp, writeEnableLatch: write_enable_latch, busyFlag: busyNow};
      configReg = '{dummyCycleSelect: dc, reservedHigh: 3'h0, topBottomSelect: tb,
                    reservedLow: 3'h0};
   end

   // ---------------------------------------------------------------
   // Values handed to the link domain
   // ---------------------------------------------------------------
   sfsw_status_s shadow;
   logic         rstLink;

   // The link reads this copy only while select is low, when it is frozen.
   // A status poll therefore needs a fresh frame to see busy fall.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         shadow <= '0;
      end else if (csHigh && csSync[2]) begin
         shadow <= statusReg;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         rstLink <= 1'b1;
      end else begin
         rstLink <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Link receive side, rising serial clock
   // ---------------------------------------------------------------
   logic [7:0]        sh;
   logic [7:0]        inByte;
   logic [7:0]        opc;
   logic [7:0]        opcNow;
   logic [6:0]        cnt;
   logic [6:0]        nextCnt;
   logic [ADDR_W-1:0] startAddr;
   logic              inFrame;
   logic              enh;
   logic              dataGo;
   logic              dualMode;
   logic              statMode;

   assign inByte = {sh[6:0], serialIn};
   assign opcNow = (nextCnt == CNT_OPCODE) ? inByte : opc;
   assign frameCnt   = cnt;
   assign frameOpc   = opc;

   // An enhanced frame has no opcode; its first bit is an address bit.
   always_comb begin
      if (!inFrame) begin
         nextCnt = enh ? CNT_ADDR_FIRST : CNT_FIRST;
      end else if (cnt == CNT_MAX) begin
         nextCnt = cnt;
      end else begin
         nextCnt = cnt + 1'b1;
      end
   end

   // Frame capture keeps its value after select rises for the core.
   always_ff @(posedge sclk) begin
      sh  <= inByte;
      cnt <= nextCnt;
      if (!inFrame && enh) begin
         opc <= OP_FAST_READ;
      end else if (nextCnt == CNT_OPCODE) begin
         opc <= inByte;
      end
      if (nextCnt >= CNT_ADDR_FIRST && nextCnt <= CNT_ADDR_LAST) begin
         startAddr <= {startAddr[ADDR_W-2:0], serialIn};
      end
      if (nextCnt == CNT_BYTE2) begin
         frameData1 <= inByte;
      end
      if (nextCnt == CNT_BYTE3) begin
         frameData2 <= inByte;
      end
   end

   always_ff @(posedge sclk or posedge rstLink) begin
      if (rstLink) begin
         enh <= 1'b0;
      end else if (nextCnt == CNT_OPCODE && inByte == OP_ENH_RESET) begin
         enh <= 1'b0;
      end else if (nextCnt == CNT_MODE_END && opc == OP_FAST_READ) begin
         enh <= (inByte[7:4] == ~inByte[3:0]);
      end
   end

   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         inFrame  <= 1'b0;
         dataGo   <= 1'b0;
         dualMode <= 1'b0;
         statMode <= 1'b0;
      end else begin
         inFrame <= 1'b1;
         if (readStart(opcNow) != CNT_NONE && nextCnt == readStart(opcNow)
             && !(shadow.busyFlag
                  && (opcNow == OP_FAST_READ || opcNow == OP_DUAL_READ))) begin
            dataGo   <= 1'b1;
            dualMode <= (opcNow == OP_DUAL_READ);
            statMode <= (opcNow == OP_READ_STATUS);
         end
      end
   end

   // ---------------------------------------------------------------
   // Link transmit side, falling serial clock
   // ---------------------------------------------------------------
   logic [7:0]        outSh;
   logic [2:0]        remain;
   logic [ADDR_W-1:0] readPtr;
   logic              started;
   logic              drive;

   assign arrayAddr = started ? readPtr : startAddr;

   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         drive   <= 1'b0;
         started <= 1'b0;
         remain  <= 3'h0;
         outSh   <= 8'h00;
         readPtr <= '0;
      end else if (dataGo) begin
         drive <= 1'b1;
         if (remain == 3'h0) begin
            outSh  <= statMode ? shadow : arrayData;
            remain <= dualMode ? SHIFTS_DUAL : SHIFTS_SINGLE;
            if (!statMode) begin
               readPtr <= ADDR_W'(arrayAddr + 1'b1);
               started <= 1'b1;
            end
         end else begin
            outSh  <= dualMode ? {outSh[5:0], 2'b00} : {outSh[6:0], 1'b0};
            remain <= remain - 1'b1;
         end
      end
   end

   always_comb begin
      linkOut.dualOutputLine1 = outSh[7];
      linkOut.line1Oe         = drive;
      linkOut.dualOutputLine0 = outSh[6];
      linkOut.line0Oe         = drive && dualMode;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_swStart;
      @(posedge clock) disable iff (!nrst)
      cmdSw |=> statusReg.busyFlag && write_enable_latch;
   endproperty
   a_swStart: assert property (p_swStart) else $error("write cycle did not start");

   property p_swLength;
      @(posedge clock) disable iff (!nrst)
      $rose(wstate == WS_WRITE) |-> (wstate == WS_WRITE) [*2];
   endproperty
   a_swLength: assert property (p_swLength) else $error("write cycle too short");

   property p_swEnd;
      @(posedge clock) disable iff (!nrst)
      swDone |=> !write_enable_latch && wstate == WS_IDLE;
   endproperty
   a_swEnd: assert property (p_swEnd) else $error("latch not cleared at cycle end");

   property p_needLatch;
      @(posedge clock) disable iff (!nrst)
      $rose(wstate == WS_WRITE) |-> $past(write_enable_latch);
   endproperty
   a_needLatch: assert property (p_needLatch) else $error("write without latch");

   property p_hpmRefuse;
      @(posedge clock) disable iff (!nrst)
      (csRise && hardwareProtectionMode) |=> $stable(bp) && $stable(status_write_disable_bit)
                                             && !$rose(wstate == WS_WRITE);
   endproperty
   a_hpmRefuse: assert property (p_hpmRefuse) else $error("write taken in hpm");

   property p_boundary;
      @(posedge clock) disable iff (!nrst)
      $rose(wstate == WS_WRITE) |-> $past(frameCnt == CNT_BYTE2 || frameCnt == CNT_BYTE3);
   endproperty
   a_boundary: assert property (p_boundary) else $error("write off byte boundary");

   property p_hpmDef;
      @(posedge clock) disable iff (!nrst)
      hardwareProtectionMode |-> status_write_disable_bit && !qe && !wpHigh;
   endproperty
   a_hpmDef: assert property (p_hpmDef) else $error("hpm without its cause");

   property p_quadOff;
      @(posedge clock) disable iff (!nrst)
      qe |-> !hardwareProtectionMode;
   endproperty
   a_quadOff: assert property (p_quadOff) else $error("hpm with quad enabled");

   property p_hpmFrozen;
      @(posedge clock) disable iff (!nrst)
      hardwareProtectionMode && !cmdSw |=> $stable(bp) && $stable(status_write_disable_bit);
   endproperty
   a_hpmFrozen: assert property (p_hpmFrozen) else $error("protect bits moved");

   property p_dualPair;
      @(negedge sclk) disable iff (csN)
      linkOut.line0Oe |-> linkOut.line1Oe && dualMode;
   endproperty
   a_dualPair: assert property (p_dualPair) else $error("line0 driven alone");

   c_swAccept: cover property (@(posedge clock) disable iff (!nrst) cmdSw);
   c_hpmBlock: cover property (@(posedge clock) disable iff (!nrst)
                               csRise && hardwareProtectionMode && write_enable_latch);
   c_swDone:   cover property (@(posedge clock) disable iff (!nrst) swDone);
   c_dualRead: cover property (@(negedge sclk) disable iff (csN) linkOut.line0Oe);

endmodule // sfsw_flash_core

`default_nettype wire

// >>> test/sfsw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Host controller model. The link clock only runs inside frames.
// ----------------------------------------------------------------
module sfsw_host_model (
   // Serial link
   output var  logic                 sclk,
   output var  logic                 csN,
   output var  logic                 serialIn,
   input  wire sfsw_pkg::sfsw_link_s linkOut
);
   import sfsw_pkg::*;
   localparam int HALF = 24;
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      serialIn = 1'b0;
   end
   task automatic start();
      csN = 1'b0;
      #HALF;
   endtask
   // Partial bytes are allowed so a frame can end off a byte boundary.
   task automatic send(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         serialIn = b[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
   endtask
   // A line the device does not drive reads as z, so it matches only an expected z.
   task automatic recv(input logic dual, output logic [7:0] b);
      logic l1;
      logic l0;
      for (int i = 0; i < (dual ? 4 : 8); i++) begin
         serialIn = ~serialIn;
         #HALF sclk = 1'b1;
         l1 = linkOut.line1Oe ? linkOut.dualOutputLine1 : 1'bz;
         l0 = linkOut.line0Oe ? linkOut.dualOutputLine0 : 1'bz;
         b = dual ? {b[5:0], l1, l0} : {b[6:0], l1};
         #HALF sclk = 1'b0;
      end
   endtask
   task automatic stop();
      #HALF csN = 1'b1;
      serialIn = ~serialIn;
      #100;
   endtask
endmodule // sfsw_host_model
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sfsw_pkg::*;
   localparam int WCYC = 20;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic sclk, csN, serialIn;
   logic writeProtectIo2PinN = 1'b1;
   logic peBusy = 1'b0;
   logic [5:0] peBlock = 6'h3f;
   logic [7:0] arrayAddr, arrayData;
   logic peBlocked, hardwareProtectionMode, softwareProtectionMode;
   logic [3:0] quadDummyClocks;
   logic [23:0] got;
   logic [7:0] modeByte = 8'h00;
   sfsw_link_s linkOut;
   sfsw_status_s statusReg;
   sfsw_config_s configReg;
   int failures = 0;
   int compares = 0;
   always #5 clock = ~clock;
   assign arrayData = arrayAddr ^ 8'h5a;
   sfsw_flash_core #(.ADDR_W(8), .WRITE_CYCLES(WCYC)) dut_u (.clock(clock), .nrst(nrst),
      .sclk(sclk), .csN(csN), .serialIn(serialIn), .writeProtectIo2PinN(writeProtectIo2PinN),
      .linkOut(linkOut), .arrayAddr(arrayAddr), .arrayData(arrayData), .peBusy(peBusy),
      .peBlock(peBlock), .peBlocked(peBlocked), .statusReg(statusReg), .configReg(configReg),
      .hardwareProtectionMode(hardwareProtectionMode),
      .softwareProtectionMode(softwareProtectionMode), .quadDummyClocks(quadDummyClocks));
   sfsw_host_model host_u (.sclk(sclk), .csN(csN), .serialIn(serialIn), .linkOut(linkOut));
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] s, input logic [7:0] c, input int n, input logic en);
      if (en) begin
         host_u.start();
         host_u.send(OP_WRITE_ENABLE, 8);
         host_u.stop();
      end
      host_u.start();
      host_u.send(OP_STATUS_WRITE, 8);
      host_u.send(s, (n > 8) ? 8 : n);
      if (n > 8) host_u.send(c, n - 8);
      host_u.stop();
      cycles(8);
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] a, input int pre, input logic dual);
      host_u.start();
      host_u.send(op, 8);
      for (int k = 0; k < pre; k++) host_u.send((k == 2) ? a : ((k == 3) ? modeByte : 8'h00), 8);
      for (int i = 0; i < 3; i++) host_u.recv(dual, got[23-8*i -: 8]);
      host_u.stop();
      check("lineDrive", {6'h00, linkOut.line1Oe, linkOut.line0Oe}, 8'h00);
      cycles(1);
   endtask
   task automatic t_refuse();
      wr(8'h3c, 8'h00, 8, 1'b0);
      cycles(WCYC + 8);
      check("noLatch", statusReg, 8'h00);
      check("dummyDefault", quadDummyClocks, 8'h06);
   endtask
   task automatic t_boundary();
      wr(8'h80, 8'h00, 4, 1'b1);
      wr(8'h80, 8'h00, 12, 1'b0);
      cycles(WCYC + 8);
      check("offBoundary", statusReg, 8'h02);
   endtask
   task automatic t_write();
      wr(8'h3f, 8'h00, 8, 1'b1);
      check("busySet", statusReg[0], 8'h01);
      cycles(WCYC + 8);
      check("written", statusReg, 8'h3c);
      check("blocked", peBlocked, 8'h01);
      rd(OP_READ_STATUS, 8'h00, 0, 1'b0);
      check("statusLink", got[23:16], 8'h3c);
      wr(8'h00, 8'h00, 8, 1'b1);
      cycles(WCYC + 8);
      check("unblocked", peBlocked, 8'h00);
   endtask
   task automatic t_busy();
      peBusy = 1'b1;
      rd(OP_FAST_READ, 8'h10, 4, 1'b0);
      check("fastRefused", got[23:16], 8'hzz);
      rd(OP_DUAL_READ, 8'h10, 4, 1'b1);
      check("dualRefused", got[23:16], 8'hzz);
      peBusy = 1'b0;
   endtask
   task automatic t_reads();
      rd(OP_READ, 8'hfe, 3, 1'b0);
      check("read", got, {8'ha4, 8'ha5, 8'h5a});
      rd(OP_FAST_READ, 8'h40, 4, 1'b0);
      check("fast", got, {8'h1a, 8'h1b, 8'h18});
      rd(OP_DUAL_READ, 8'hff, 4, 1'b1);
      check("dual", got, {8'ha5, 8'h5a, 8'h5b});
   endtask
   // A mode byte with complementary nibbles lets the next frame start straight with the address.
   task automatic t_enhanced();
      modeByte = 8'ha5;
      rd(OP_FAST_READ, 8'h20, 4, 1'b0);
      check("enhEnter", got[23:16], 8'h7a);
      host_u.start();
      host_u.send(8'h00, 8);
      host_u.send(8'h00, 8);
      host_u.send(8'h30, 8);
      host_u.send(8'hff, 8);
      host_u.recv(1'b0, got[23:16]);
      host_u.stop();
      check("enhKeep", got[23:16], 8'h6a);
      modeByte = 8'h00;
      rd(OP_READ, 8'h50, 3, 1'b0);
      check("enhExit", got[23:16], 8'h0a);
   endtask
   task automatic t_config();
      wr(8'h00, 8'h80, 16, 1'b1);
      cycles(WCYC + 8);
      check("config", configReg, 8'h80);
      check("dummyEight", quadDummyClocks, 8'h08);
   endtask
   task automatic t_protect();
      wr(8'h80, 8'h00, 8, 1'b1);
      cycles(WCYC + 8);
      writeProtectIo2PinN = 1'b0;
      cycles(6);
      check("hpmOn", hardwareProtectionMode, 8'h01);
      check("spmOff", softwareProtectionMode, 8'h00);
      wr(8'h00, 8'h00, 8, 1'b1);
      cycles(WCYC + 8);
      check("hpmHolds", {statusReg[7:2], 2'b00}, 8'h80);
      writeProtectIo2PinN = 1'b1;
      cycles(6);
      check("hpmOff", hardwareProtectionMode, 8'h00);
      check("spmOn", softwareProtectionMode, 8'h01);
      wr(8'hc0, 8'h00, 8, 1'b1);
      cycles(WCYC + 8);
      writeProtectIo2PinN = 1'b0;
      cycles(6);
      check("quadNoHpm", hardwareProtectionMode, 8'h00);
      wr(8'h00, 8'h00, 8, 1'b1);
      cycles(WCYC + 8);
      check("quadWrite", statusReg, 8'h00);
   endtask
   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      cycles(3);
      nrst = 1'b1;
      cycles(4);
      t_refuse();
      t_boundary();
      t_write();
      t_busy();
      t_reads();
      t_enhanced();
      t_config();
      t_protect();
      print_verdict();
   end
   // A hung handshake would otherwise stall the run forever.
   initial begin
      #800000;
      failures++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
